/* File: hdl/tsd_consts.vh */
// Constants for the thermal shutdown and measure-select block.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef TSD_CONSTS_VH
`define TSD_CONSTS_VH

// Register word indices; byte address is four times the index
`define TSD_IDX_CTRL1   10'h001
`define TSD_IDX_DIAG    10'h007
`define TSD_IDX_TSDCFG  10'h010
`define TSD_IDX_MEAS    10'h011
`define TSD_IDX_IRQST   10'h012
`define TSD_IDX_IRQMSK  10'h013
`define TSD_IDX_ALARM   10'h044

// Control register 1 fields
`define TSD_C1_INH      0
`define TSD_C1_RNG      3:1
`define TSD_C1_PD       4
`define TSD_C1_RST      5'h00
`define TSD_RNG_EXT2    3'h6

// Shutdown configuration fields
`define TSD_CF_THR      1:0
`define TSD_CF_LAT      2
`define TSD_CF_RST      3'h7

// Trip thresholds in degrees C
`define TSD_THR_100     8'h64
`define TSD_THR_110     8'h6E
`define TSD_THR_120     8'h78
`define TSD_THR_130     8'h82

// Threshold select codes; any other code is the top step
`define TSD_THC_100     2'h0
`define TSD_THC_110     2'h1
`define TSD_THC_120     2'h2

// Measure configuration fields
`define TSD_MS_SRC      1:0
`define TSD_MS_GAIN     2
`define TSD_MS_IGAIN    3
`define TSD_MS_TRI      4
`define TSD_MS_RST      5'h00

// Diagnostic register fields and codes
`define TSD_DG_SEL      2:0
`define TSD_DG_DEN      3
`define TSD_DG_DIDX     6:4
`define TSD_DG_RST      7'h00
`define TSD_DG_NONE     3'h0
`define TSD_DG_PTL      3'h1
`define TSD_DG_PTH      3'h2
`define TSD_DG_REFL     3'h3
`define TSD_DG_REFH     3'h4

// Measure output route codes
`define TSD_MO_PTL      3'h4
`define TSD_MO_PTH      3'h5
`define TSD_MO_REFL     3'h6
`define TSD_MO_REFH     3'h7

// Alarm status bits and interrupt bits
`define TSD_AL_FLAG     0
`define TSD_AL_NOW      1
`define TSD_AL_PIN      2
`define TSD_IRQ_TRIP    0
`define TSD_IRQ_COOL    1
`define TSD_IRQ_N       2
`define TSD_MSK_RST     2'h0

// Bus answers
`define TSD_RESP_OKAY   2'h0
`define TSD_RESP_SLVERR 2'h2
`define TSD_ZERO32      32'h0000_0000

`endif

/* File: hdl/tsd_sticky.v */
// One sticky flag: hardware sets it, a clear pulse drops it.
// Assumes set and clear are synchronous to aclk.
`default_nettype none

module tsd_sticky #(
	parameter RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire aclk,
	input  wire aresetn,
	// Set and clear strobes
	input  wire set,
	input  wire clr,
	// Flag
	output reg  q
);

	// Set wins over a clear in the same cycle, so no event is lost
	always @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST_VAL;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule // tsd_sticky

`default_nettype wire

/* File: hdl/tsd_top.v */
// Thermal shutdown control and measure-output selection, AXI4-Lite slave.
// Assumes digital temperature codes in degrees C, synchronous to aclk.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "tsd_consts.vh"
`default_nettype none

module tsd_top (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Power-stage sensor temperatures
	input  wire [7:0]  stage_one_b_temp,
	input  wire [7:0]  stage_two_a_temp,
	// Open-drain alarm pin
	input  wire        overtemp_alarm_pin_in,
	output wire        overtemp_alarm_pin_out,
	output wire        overtemp_alarm_pin_oe,
	// Force amplifier and sensor enables
	output reg         force_amp_enable,
	output reg         shutdown_sensor_en,
	output wire        die_temp_sensor_en,
	// Measure output control
	output reg  [2:0]  measure_output_route,
	output reg         measure_output_gain_select,
	output reg         current_measure_gain_select,
	output reg         measure_output_tristate,
	// Diagnostic diode to general purpose output
	output reg  [7:0]  gp_out_diode_sel,
	// Interrupt
	output wire        irq
);

	// Software registers
	reg  [4:0]  ctrl1_reg;          // Soft inhibit, range, power-down
	reg  [2:0]  tsdcfg_reg;         // Threshold and latch mode
	reg  [4:0]  meas_reg;           // Measure source, gains, tristate
	reg  [6:0]  diag_reg;           // Diagnostic routing
	reg  [1:0]  irq_mask_reg;       // Interrupt mask

	// Write channel holding
	reg         aw_full_reg;
	reg  [9:0]  aw_idx_reg;
	reg         w_full_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;

	// Temperature path
	wire [7:0]  thr_degc;           // Threshold in degrees C
	wire [7:0]  active_temp;        // Sensor of the active stage
	wire        overtemp_now;       // Combinational trip condition
	reg         overtemp_reg;       // Registered trip condition
	reg         overtemp_d_reg;     // Previous condition, for edges

	// Flags
	wire        alarm_flag;
	wire [1:0]  irq_status;
	wire [1:0]  irq_set;
	wire        alarm_clr;
	wire        irq_clr;
	wire        alarm_assert;

	// Bus decode
	wire        wr_fire;
	wire        wr_lane0;
	wire        rd_fire;
	wire [9:0]  rd_idx;
	reg  [31:0] rd_mux;
	reg         rd_hit;
	wire        wr_hit;
	wire        ctrl1_wr;
	wire        inh_wr_val;

	// Unused protection bits are accepted and ignored
	wire        unused_ok;
	assign unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1]};

	// Address and data handshakes; a held word blocks the next one
	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_arready = ~s_axi_rvalid;

	// Commit once both halves are held and no response is pending
	assign wr_fire  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	assign wr_lane0 = w_strb_reg[0];
	assign rd_fire  = s_axi_arvalid & ~s_axi_rvalid;
	assign rd_idx   = s_axi_araddr[11:2];

	// Write address and data are captured independently
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_idx_reg  <= 10'h000;
			w_full_reg  <= 1'b0;
			w_data_reg  <= `TSD_ZERO32;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[11:2];
			end else if (wr_fire) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// Write decode; read-only words accept and ignore data
	assign wr_hit = (aw_idx_reg == `TSD_IDX_CTRL1) | (aw_idx_reg == `TSD_IDX_DIAG) |
		(aw_idx_reg == `TSD_IDX_TSDCFG) | (aw_idx_reg == `TSD_IDX_MEAS) |
		(aw_idx_reg == `TSD_IDX_IRQST) | (aw_idx_reg == `TSD_IDX_IRQMSK) |
		(aw_idx_reg == `TSD_IDX_ALARM);

	// Write response, one per committed write
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TSD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Soft inhibit cannot be re-armed while the alarm flag still stands
	assign ctrl1_wr   = wr_fire & wr_lane0 & (aw_idx_reg == `TSD_IDX_CTRL1);
	assign inh_wr_val = w_data_reg[`TSD_C1_INH] & ~alarm_flag;

	// Control register 1; a trip overrides any write to the inhibit bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_reg <= `TSD_C1_RST;
		end else begin
			if (ctrl1_wr) begin
				ctrl1_reg[`TSD_C1_RNG] <= w_data_reg[`TSD_C1_RNG];
				ctrl1_reg[`TSD_C1_PD]  <= w_data_reg[`TSD_C1_PD];
			end
			if (overtemp_reg) begin
				ctrl1_reg[`TSD_C1_INH] <= 1'b0;
			end else if (ctrl1_wr) begin
				ctrl1_reg[`TSD_C1_INH] <= inh_wr_val;
			end
		end
	end

	// Remaining configuration registers, byte lane 0 only
	always @(posedge aclk) begin
		if (!aresetn) begin
			tsdcfg_reg   <= `TSD_CF_RST;
			meas_reg     <= `TSD_MS_RST;
			diag_reg     <= `TSD_DG_RST;
			irq_mask_reg <= `TSD_MSK_RST;
		end else if (wr_fire && wr_lane0) begin
			case (aw_idx_reg)
				`TSD_IDX_TSDCFG: begin
					tsdcfg_reg <= w_data_reg[2:0];
				end
				`TSD_IDX_MEAS: begin
					meas_reg <= w_data_reg[4:0];
				end
				`TSD_IDX_DIAG: begin
					diag_reg <= w_data_reg[6:0];
				end
				`TSD_IDX_IRQMSK: begin
					irq_mask_reg <= w_data_reg[1:0];
				end
				default: begin
					irq_mask_reg <= irq_mask_reg;
				end
			endcase
		end
	end

	// Threshold decode; the reset code selects the top step
	assign thr_degc = (tsdcfg_reg[`TSD_CF_THR] == `TSD_THC_100) ? `TSD_THR_100 :
		(tsdcfg_reg[`TSD_CF_THR] == `TSD_THC_110) ? `TSD_THR_110 :
		(tsdcfg_reg[`TSD_CF_THR] == `TSD_THC_120) ? `TSD_THR_120 : `TSD_THR_130;

	// Only the triggering sub-stage of the active stage is watched
	assign active_temp = (ctrl1_reg[`TSD_C1_RNG] == `TSD_RNG_EXT2) ?
		stage_two_a_temp : stage_one_b_temp;

	// Strictly above threshold, and never in power-down
	assign overtemp_now = ~ctrl1_reg[`TSD_C1_PD] & (active_temp > thr_degc);

	// Registered condition and its previous value for edge events
	always @(posedge aclk) begin
		if (!aresetn) begin
			overtemp_reg   <= 1'b0;
			overtemp_d_reg <= 1'b0;
		end else begin
			overtemp_reg   <= overtemp_now;
			overtemp_d_reg <= overtemp_reg;
		end
	end

	// Read-clear strobes, taken on the read handshake
	assign alarm_clr = rd_fire & (rd_idx == `TSD_IDX_ALARM);
	assign irq_clr   = rd_fire & (rd_idx == `TSD_IDX_IRQST);

	// Alarm flag; a standing condition re-sets it after a read
	tsd_sticky #(
		.RST_VAL (1'b0)
	) u_alarm_flag (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (overtemp_reg),
		.clr     (alarm_clr),
		.q       (alarm_flag)
	);

	// Interrupt events: trip onset and cool-down
	assign irq_set[`TSD_IRQ_TRIP] = overtemp_reg & ~overtemp_d_reg;
	assign irq_set[`TSD_IRQ_COOL] = ~overtemp_reg & overtemp_d_reg;

	// One sticky status bit per event
	genvar gi;
	generate
		for (gi = 0; gi < `TSD_IRQ_N; gi = gi + 1) begin : g_irq
			tsd_sticky #(
				.RST_VAL (1'b0)
			) u_irq_bit (
				.aclk    (aclk),
				.aresetn (aresetn),
				.set     (irq_set[gi]),
				.clr     (irq_clr),
				.q       (irq_status[gi])
			);
		end
	endgenerate

	// Level interrupt while any unmasked status bit stands
	assign irq = |(irq_status & irq_mask_reg);

	// Pin follows the flag when latched, the condition otherwise
	assign alarm_assert = tsdcfg_reg[`TSD_CF_LAT] ? alarm_flag : overtemp_reg;

	// Open-drain: only ever pulls low, enable marks the alarm
	assign overtemp_alarm_pin_out = 1'b0;
	assign overtemp_alarm_pin_oe  = alarm_assert;

	// Die temperature sensor has no power-down gating
	assign die_temp_sensor_en = 1'b1;

	// Read mux; reserved bits read as zero
	always @* begin
		rd_mux = `TSD_ZERO32;
		rd_hit = 1'b1;
		case (rd_idx)
			`TSD_IDX_CTRL1:  rd_mux[4:0] = ctrl1_reg;
			`TSD_IDX_DIAG:   rd_mux[6:0] = diag_reg;
			`TSD_IDX_TSDCFG: rd_mux[2:0] = tsdcfg_reg;
			`TSD_IDX_MEAS:   rd_mux[4:0] = meas_reg;
			`TSD_IDX_IRQST:  rd_mux[1:0] = irq_status;
			`TSD_IDX_IRQMSK: rd_mux[1:0] = irq_mask_reg;
			`TSD_IDX_ALARM: begin
				rd_mux[`TSD_AL_FLAG] = alarm_flag;
				rd_mux[`TSD_AL_NOW]  = overtemp_reg;
				rd_mux[`TSD_AL_PIN]  = overtemp_alarm_pin_in;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data channel; data holds until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `TSD_ZERO32;
			s_axi_rresp  <= `TSD_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Registered analog controls; diagnostic selection overrides source
	always @(posedge aclk) begin
		if (!aresetn) begin
			force_amp_enable            <= 1'b0;
			shutdown_sensor_en          <= 1'b0;
			measure_output_route        <= 3'h0;
			measure_output_gain_select         <= 1'b0;
			current_measure_gain_select <= 1'b0;
			measure_output_tristate     <= 1'b0;
			gp_out_diode_sel            <= 8'h00;
		end else begin
			// Amp runs only while the soft inhibit bit is set
			force_amp_enable   <= ctrl1_reg[`TSD_C1_INH] & ~overtemp_reg;
			shutdown_sensor_en <= ~ctrl1_reg[`TSD_C1_PD];
			case (diag_reg[`TSD_DG_SEL])
				`TSD_DG_PTL:  measure_output_route <= `TSD_MO_PTL;
				`TSD_DG_PTH:  measure_output_route <= `TSD_MO_PTH;
				`TSD_DG_REFL: measure_output_route <= `TSD_MO_REFL;
				`TSD_DG_REFH: measure_output_route <= `TSD_MO_REFH;
				default:      measure_output_route <= {1'b0, meas_reg[`TSD_MS_SRC]};
			endcase
			measure_output_gain_select         <= meas_reg[`TSD_MS_GAIN];
			current_measure_gain_select <= meas_reg[`TSD_MS_IGAIN];
			measure_output_tristate     <= meas_reg[`TSD_MS_TRI];
			// One-hot diode select; anode to output, cathode to ground
			if (diag_reg[`TSD_DG_DEN]) begin
				gp_out_diode_sel <= 8'h01 << diag_reg[`TSD_DG_DIDX];
			end else begin
				gp_out_diode_sel <= 8'h00;
			end
		end
	end

endmodule // tsd_top

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for tsd_top over AXI4-Lite.
// Assumes the design files under hdl/ and the far side model.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// Register byte addresses
	localparam logic [11:0] A_C1 = 12'h004, A_DG = 12'h01C, A_CF = 12'h040;
	localparam logic [11:0] A_MS = 12'h044, A_IS = 12'h048, A_IM = 12'h04C;
	localparam logic [11:0] A_AL = 12'h110;

	logic        aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  h1 = 8'h19, h2 = 8'h19, t1, t2, diode;
	logic        awready, wready, bvalid, arready, rvalid, pin, ooe, oout;
	logic        amp, sen, den, mg, ig, tri_s, irq;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  route;
	logic [7:0]  thr [4] = '{8'h64, 8'h6E, 8'h78, 8'h82};
	logic [4:0]  ms [4] = '{5'h00, 5'h05, 5'h0A, 5'h1F};
	int          err_count = 0, check_count = 0;

	// Free-running clock, 40 ns period
	always #20 aclk = ~aclk;

	tsd_far i_far (.aclk(aclk), .heat_one(h1), .heat_two(h2), .stage_one_b_temp(t1),
		.stage_two_a_temp(t2), .pin_out(oout), .pin_oe(ooe), .pin_level(pin));

	tsd_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.stage_one_b_temp(t1), .stage_two_a_temp(t2), .overtemp_alarm_pin_in(pin),
		.overtemp_alarm_pin_out(oout), .overtemp_alarm_pin_oe(ooe), .force_amp_enable(amp),
		.shutdown_sensor_en(sen), .die_temp_sensor_en(den), .measure_output_route(route),
		.measure_output_gain_select(mg), .current_measure_gain_select(ig),
		.measure_output_tristate(tri_s), .gp_out_diode_sel(diode), .irq(irq));

	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Write: address and data offered together, response awaited
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bit done = 0;
		int n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				done = 1;
				rs = bresp;
				bready <= 0;
			end
		end
		chk(done, 1);
	endtask

	// Read: result left in rd and rs
	task automatic rdr(input logic [11:0] a);
		bit done = 0;
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				done = 1;
				rd = rdata;
				rs = rresp;
				rready <= 0;
			end
		end
		chk(done, 1);
	endtask

	// Cool down, show the amp stays off, then clear and re-enable
	task automatic rec(input logic [31:0] c);
		h1 <= 8'h19;
		h2 <= 8'h19;
		repeat (4) @(posedge aclk);
		chk(amp, 0);
		rdr(A_AL);
		chk(rd[2:0], 3'b101);
		wr(A_C1, c);
		repeat (2) @(posedge aclk);
		chk(amp, c[0]);
	endtask

	task report_and_stop;
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		rdr(A_CF);
		chk(rd, 32'h0000_0007);
		chk({amp, den}, 2'b01);
		wr(A_IM, 32'h0000_0001);
		// Every threshold: equal holds, one above trips
		for (int i = 0; i < 4; i++) begin
			wr(A_CF, i);
			wr(A_C1, 32'h0000_0001);
			h1 <= thr[i];
			repeat (4) @(posedge aclk);
			chk(ooe, 0);
			h1 <= thr[i] + 8'h01;
			repeat (4) @(posedge aclk);
			chk({ooe, amp, irq}, 3'b101);
			rdr(A_C1);
			chk(rd, 0);
			rec(32'h0000_0001);
			chk(ooe, 0);
			rdr(A_IS);
			chk(rd, 32'h0000_0003);
			@(posedge aclk);
			chk(irq, 0);
		end
		// Latched, masked: pin holds until the alarm read
		wr(A_IM, 0);
		wr(A_CF, 32'h0000_0007);
		h1 <= 8'h83;
		repeat (4) @(posedge aclk);
		chk({ooe, irq}, 2'b10);
		h1 <= 8'h19;
		repeat (4) @(posedge aclk);
		chk(ooe, 1);
		wr(A_C1, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(amp, 0);
		rdr(A_AL);
		chk(rd[2:0], 3'b001);
		repeat (2) @(posedge aclk);
		chk(ooe, 0);
		wr(A_C1, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(amp, 1);
		rdr(A_IS);
		// Stage selection by range
		wr(A_CF, 0);
		wr(A_C1, 32'h0000_000D);
		h1 <= 8'hC8;
		repeat (4) @(posedge aclk);
		chk(ooe, 0);
		h2 <= 8'hC8;
		repeat (4) @(posedge aclk);
		chk(ooe, 1);
		rec(32'h0000_0009);
		h2 <= 8'hC8;
		repeat (4) @(posedge aclk);
		chk({ooe, amp}, 2'b01);
		// Power-down: no trip, die sensor stays on
		wr(A_C1, 32'h0000_0011);
		h1 <= 8'hC8;
		repeat (4) @(posedge aclk);
		chk({ooe, sen, den}, 3'b001);
		h1 <= 8'h19;
		h2 <= 8'h19;
		// Measure source, gains and tristate
		for (int i = 0; i < 4; i++) begin
			wr(A_MS, ms[i]);
			repeat (2) @(posedge aclk);
			chk({tri_s, ig, mg, route}, {ms[i][4:2], 1'b0, ms[i][1:0]});
		end
		// Diagnostic routes and diode select
		for (int i = 1; i < 5; i++) begin
			wr(A_DG, i | 8 | (i << 4));
			repeat (2) @(posedge aclk);
			chk(route, i + 3);
			chk(diode, 1 << i);
		end
		// Unused selection falls back to the measure source, diode off
		wr(A_DG, 32'h0000_0005);
		repeat (2) @(posedge aclk);
		chk({route, diode}, {3'h3, 8'h00});
		// Unmapped read and read-only write
		rdr(12'h0F0);
		chk({rs, rd[1:0]}, 4'b1000);
		wr(A_AL, 32'h0000_0007);
		chk(rs, 0);
		report_and_stop();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		report_and_stop();
	end
endmodule // tb

`default_nettype wire

/* File: test/tsd_far.sv */
// Far side model: power-stage sensors and the pulled-up alarm line.
// Assumes the bench commands temperatures on the rising edge of aclk.
`default_nettype none

module tsd_far (
	// Clock
	input wire logic       aclk,
	// Commanded temperatures
	input wire logic [7:0] heat_one,
	input wire logic [7:0] heat_two,
	// Sensor codes to the block
	output var logic [7:0] stage_one_b_temp,
	output var logic [7:0] stage_two_a_temp,
	// Open-drain pin
	input wire logic       pin_out,
	input wire logic       pin_oe,
	output logic           pin_level
);
	// Sensors report once per cycle, so a change lands one edge late
	always @(posedge aclk) begin
		stage_one_b_temp <= heat_one;
		stage_two_a_temp <= heat_two;
	end

	// Pull-up wins unless the block sinks the line
	assign pin_level = (pin_oe && !pin_out) ? 1'b0 : 1'b1;
endmodule // tsd_far

`default_nettype wire

/* File: test/tsd_props.sv */
// Port checker for the thermal shutdown block.
// Assumes it is bound onto tsd_top and sees only that module's ports.
`default_nettype none

module tsd_props (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Bus handshakes
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Sensors
	input wire logic [7:0] stage_one_b_temp,
	input wire logic [7:0] stage_two_a_temp,
	// Protection outputs
	input wire logic       shutdown_sensor_en,
	input wire logic       die_temp_sensor_en,
	input wire logic       force_amp_enable,
	input wire logic       overtemp_alarm_pin_out,
	input wire logic       overtemp_alarm_pin_oe
);
	// Either sensor above the lowest selectable threshold
	logic hot;
	assign hot = (stage_one_b_temp > 8'h64) || (stage_two_a_temp > 8'h64);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Alarm onset, as seen on the open-drain enable
	sequence s_trip;
		$rose(overtemp_alarm_pin_oe);
	endsequence

	a_trip_needs_heat: assert property (s_trip |-> $past(hot) || $past(hot, 2))
		else $error("alarm raised without a hot sensor");
	a_trip_stops_amp: assert property (s_trip |-> ##[0:1] !force_amp_enable)
		else $error("force amp still running after trip");
	a_pin_pulls_low: assert property (overtemp_alarm_pin_oe |-> !overtemp_alarm_pin_out)
		else $error("alarm pin driven high");
	a_pd_no_trip: assert property (!shutdown_sensor_en [*3] |-> !$rose(overtemp_alarm_pin_oe))
		else $error("trip while shutdown sensors are off");
	a_die_sensor_on: assert property (die_temp_sensor_en)
		else $error("die sensor disabled");
	a_amp_needs_write: assert property ($rose(force_amp_enable) |-> $past(s_axi_bvalid))
		else $error("force amp restarted without a write");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule // tsd_props

bind tsd_top tsd_props i_props (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .stage_one_b_temp(stage_one_b_temp),
	.stage_two_a_temp(stage_two_a_temp), .shutdown_sensor_en(shutdown_sensor_en),
	.die_temp_sensor_en(die_temp_sensor_en), .force_amp_enable(force_amp_enable),
	.overtemp_alarm_pin_out(overtemp_alarm_pin_out), .overtemp_alarm_pin_oe(overtemp_alarm_pin_oe));

`default_nettype wire
